// File: verif/vector_table_select_traps_tb_top.sv
// Self-checking bench for the vector table select and trap block.
module vector_table_select_traps_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic aclk, aresetn;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic fuse, bsd;
  logic [12:0] lim;
  logic [4:0] evt; // Trap events, indexed by vector number.
  logic vec_req, vec_ack_q, vec_alt_q, trap_req_q, irq_q;
  logic [6:0] vec_num;
  logic [23:0] vec_addr_q, start_pc_q, base;
  logic [2:0] trap_vec_q;
  logic [3:0] trap_prio_q;
  int n_fail, n_compared;

  vtst_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .alt_table_fuse(fuse), .boot_seg_defined(bsd),
    .boot_segment_limit(lim), .osc_fail_evt(evt[0]),
    .addr_err_evt(evt[1]), .ecc_double_bit_trap(evt[2]),
    .stack_err_evt(evt[3]), .divide_by_zero_error(evt[4]),
    .vec_req(vec_req), .vec_num(vec_num), .vec_ack_q(vec_ack_q),
    .vec_addr_q(vec_addr_q), .vec_alt_q(vec_alt_q),
    .trap_req_q(trap_req_q), .trap_vec_q(trap_vec_q),
    .trap_prio_q(trap_prio_q), .start_pc_q(start_pc_q), .irq_q(irq_q)
  );

  vtst_core_model core (
    .aclk(aclk), .vec_req(vec_req), .vec_num(vec_num),
    .vec_ack_q(vec_ack_q), .vec_addr_q(vec_addr_q), .vec_alt_q(vec_alt_q)
  );

  // Free-running 10 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register write; each channel is dropped once it has been taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      if (bvalid === 1'b1) begin
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
        bready <= 1'b0;
        return;
      end
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    chk(32'h0, 32'h1);
    complete_run();
  endtask

  // Register read compared against an expected word.
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e);
    logic t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      t = arvalid & arready;
      if (rvalid === 1'b1) begin
        chk(rdata, e);
        chk({30'h0, rresp}, 32'h0);
        @(posedge aclk);
        rready <= 1'b0;
        return;
      end
      @(posedge aclk);
      if (t) arvalid <= 1'b0;
    end
    chk(32'h0, 32'h1);
    complete_run();
  endtask

  // One vector fetch by the core, checked for table and address.
  task automatic fv(input logic [6:0] n, input logic ea,
    input logic [23:0] exp_addr);
    logic [24:0] res;
    logic ok;
    core.fetch(n, res, ok);
    chk({31'h0, ok}, 32'h1);
    chk({7'h0, res}, {7'h0, ea, exp_addr});
  endtask

  // One-cycle trap event, then time for the pending trap to show.
  task automatic pulse(input int i);
    @(posedge aclk);
    evt[i] <= 1'b1;
    @(posedge aclk);
    evt[i] <= 1'b0;
    repeat (2) @(negedge aclk);
  endtask

  // Main sequence.
  initial begin
    logic [7:0] ro [5];
    logic en;
    logic [7:0] et;
    n_fail = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    {fuse, bsd, evt} = '0;
    lim = 13'h1FF0;
    ro = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({8'h0, start_pc_q}, 32'h0);
    chk({30'h0, trap_req_q, irq_q}, 32'h0);
    foreach (ro[k]) axi_rd(ro[k], 32'h0);
    axi_rd(8'h0C, 32'h0000_1FF0);
    axi_wr(8'h0C, 32'hFFFF_FFFF, 2'h2);
    axi_wr(8'h40, 32'hFFFF_FFFF, 2'h2);
    for (int v = 0; v < 5; v++) fv(7'(v), 1'b0, 24'h4 + 24'(2 * v));
    // Vector 125 is the last entry of a table, at offset 0xFE.
    fv(7'd125, 1'b0, 24'h00_00FE);
    for (int c = 0; c < 16; c++) begin
      @(posedge aclk);
      lim <= c[3] ? 13'h0001 : 13'h1FF0;
      fuse <= c[0];
      bsd <= c[1];
      axi_wr(8'h04, {23'h0, c[2], 8'h0}, 2'h0);
      en = &c[2:0];
      base = en ? {~lim - 13'h1, 11'h0} : 24'h0;
      fv(7'd3, en, base + 24'h00_000A);
      fv(7'd125, en, base + 24'h00_00FE);
    end
    axi_wr(8'h04, 32'h0, 2'h0);
    for (int k = 0; k < 5; k++) begin
      pulse(4 - k);
      // Pending flag, vector 4 - k and priority 11 + k.
      et = 8'(8'h8B + k + (4 - k) * 16);
      chk({trap_req_q, trap_vec_q, trap_prio_q}, et);
    end
    axi_rd(8'h00, 32'h0000_001E);
    axi_rd(8'h08, 32'h0000_0002);
    axi_rd(8'h10, 32'h0000_001F);
    chk({31'h0, irq_q}, 32'h0);
    axi_wr(8'h14, 32'h0000_0004, 2'h0);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq_q}, 32'h1);
    axi_wr(8'h00, 32'h0000_001E, 2'h0);
    axi_wr(8'h08, 32'h0000_0002, 2'h0);
    axi_wr(8'h10, 32'h0000_001F, 2'h0);
    repeat (2) @(negedge aclk);
    chk({30'h0, trap_req_q, irq_q}, 32'h0);
    axi_wr(8'h04, 32'h0000_2000, 2'h0);
    axi_wr(8'h08, 32'h0000_0001, 2'h0);
    repeat (2) @(negedge aclk);
    chk({trap_req_q, trap_vec_q, trap_prio_q}, 32'h0000_00AD);
    chk({31'h0, irq_q}, 32'h1);
    // Only the oscillator status bit is unmasked, then it is raised.
    axi_wr(8'h14, 32'h0000_0001, 2'h0);
    axi_wr(8'h10, 32'h0000_001F, 2'h0);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq_q}, 32'h0);
    pulse(0);
    chk({trap_req_q, trap_vec_q, trap_prio_q}, 32'h0000_008F);
    chk({31'h0, irq_q}, 32'h1);
    // A reset in mid-run clears the control, status and mask registers and the pending trap.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({30'h0, trap_req_q, irq_q}, 32'h0);
    chk({8'h0, start_pc_q}, 32'h0);
    foreach (ro[k]) axi_rd(ro[k], 32'h0);
    complete_run();
  end
endmodule

// File: verif/vtst_core_model.sv
// Processor core model that fetches exception vector addresses.
module vtst_core_model (
  // Clock.
  input wire logic aclk,
  // Fetch request towards the block.
  output logic vec_req,
  output logic [6:0] vec_num,
  // Answer from the block.
  input wire logic vec_ack_q,
  input wire logic [23:0] vec_addr_q,
  input wire logic vec_alt_q
);
  timeunit 1ns;
  timeprecision 1ns;

  // The core idles with no request pending.
  initial begin
    vec_req = 1'b0;
    vec_num = 7'h00;
  end

  // One fetch: a single-cycle request, then a one-cycle acknowledge.
  task automatic fetch(input logic [6:0] n, output logic [24:0] res,
    output logic ack_ok);
    @(posedge aclk);
    vec_req <= 1'b1;
    vec_num <= n;
    @(posedge aclk);
    vec_req <= 1'b0;
    @(negedge aclk);
    ack_ok = (vec_ack_q === 1'b1);
    res = {vec_alt_q, vec_addr_q};
    @(negedge aclk);
    ack_ok = ack_ok && (vec_ack_q === 1'b0);
  endtask
endmodule

// File: verilog/vtst_pkg.sv
// Package with offsets, bit positions, priorities and reset values.
package vtst_pkg;

  // Width of a program memory address and of a vector table entry.
  localparam int ADDR_W = 24;
  // Width of the boot segment limit field.
  localparam int BOOT_SEGMENT_LIMIT_W = 13;
  // Width of a vector number.
  localparam int VEC_W = 7;
  // Width of the register bus byte address.
  localparam int BUS_AW = 8;

  // Register byte offsets on the register bus.
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_CTRL4 = 8'h08;
  localparam logic [7:0] OFF_SECCFG = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_LAST_VEC = 8'h18;
  localparam logic [7:0] OFF_ALT_BASE = 8'h1C;

  // Generic trap flag positions in the first control register.
  localparam int B1_OSC = 1;
  localparam int B1_STACK = 2;
  localparam int B1_ADDR = 3;
  localparam int B1_MATH = 4;
  // Control bit positions in the second control register.
  localparam int B2_ALT_SEL = 8;
  localparam int B2_SOFT_EN = 13;
  // Hard trap source flag positions in the fourth control register.
  localparam int B4_SOFT = 0;
  localparam int B4_ECC = 1;
  // Fuse position in the security configuration word.
  localparam int BS_FUSE = 15;

  // Trap vector numbers.
  localparam logic [2:0] V_OSC = 3'h0;
  localparam logic [2:0] V_ADDR = 3'h1;
  localparam logic [2:0] V_HARD = 3'h2;
  localparam logic [2:0] V_STACK = 3'h3;
  localparam logic [2:0] V_MATH = 3'h4;
  // Number of trap events tracked in the interrupt status register.
  localparam int N_TRAP = 5;

  // Fixed natural priorities of the traps.
  localparam logic [3:0] P_OSC = 4'hF;
  localparam logic [3:0] P_ADDR = 4'hE;
  localparam logic [3:0] P_HARD = 4'hD;
  localparam logic [3:0] P_STACK = 4'hC;
  localparam logic [3:0] P_MATH = 4'hB;
  localparam logic [3:0] P_NONE = 4'h0;

  // Offset of vector 0 from its table base.
  localparam logic [23:0] VEC0_OFF = 24'h00_0004;
  // Size of one boot segment page, as a left shift.
  localparam int PAGE_SHIFT = 11;
  // Address where execution starts after any reset.
  localparam logic [23:0] RESET_PC = 24'h00_0000;

  // Reset value of every writable register word.
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: verilog/vtst_top.sv
// Vector table select and trap vector logic with an AXI4-Lite slave.
module vtst_top #(
  parameter int VEC_W = 7,
  parameter int BOOT_SEGMENT_LIMIT_W = 13
) (
  // Clock and synchronous active-low reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [vtst_pkg::BUS_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [vtst_pkg::BUS_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration word levels.
  input wire logic alt_table_fuse,
  input wire logic boot_seg_defined,
  input wire logic [BOOT_SEGMENT_LIMIT_W-1:0] boot_segment_limit,
  // One-cycle trap event pulses from the core.
  input wire logic osc_fail_evt,
  input wire logic addr_err_evt,
  input wire logic stack_err_evt,
  input wire logic divide_by_zero_error,
  input wire logic ecc_double_bit_trap,
  // Core vector fetch port.
  input wire logic vec_req,
  input wire logic [VEC_W-1:0] vec_num,
  output logic vec_ack_q,
  output logic [23:0] vec_addr_q,
  output logic vec_alt_q,
  // Pending trap towards the core.
  output logic trap_req_q,
  output logic [2:0] trap_vec_q,
  output logic [3:0] trap_prio_q,
  // Start address after reset and the interrupt line.
  output logic [23:0] start_pc_q,
  output logic irq_q
);

  // Control registers and interrupt status.
  logic [15:0] ctrl1_q;
  logic [15:0] ctrl2_q;
  logic [15:0] ctrl4_q;
  logic [vtst_pkg::N_TRAP-1:0] stat_q;
  logic [vtst_pkg::N_TRAP-1:0] mask_q;
  // Write channel capture.
  logic aw_got_q;
  logic w_got_q;
  logic [vtst_pkg::BUS_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  // Write strobe and lane-masked data.
  logic do_wr;
  logic [31:0] wmask;
  logic [31:0] wd;
  // Per-register write selects.
  logic wr1;
  logic wr2;
  logic wr4;
  logic wrst;
  logic wrmk;
  // Trap pending terms.
  logic hard_pend;
  logic [vtst_pkg::N_TRAP-1:0] trap_evt;
  // Generator outputs.
  logic alt_en;
  logic [23:0] alt_base;
  logic [23:0] calc_addr;
  // Register select of the read address, bit 3 flags a hit.
  logic [3:0] rd_sel;

  // Decodes a byte address into a register select, bit 3 flags a hit.
  function automatic logic [3:0] reg_sel(
    input logic [vtst_pkg::BUS_AW-1:0] a);
    logic [3:0] s;
    s = 4'h0;
    unique case (a)
      vtst_pkg::OFF_CTRL1: s = 4'h8;
      vtst_pkg::OFF_CTRL2: s = 4'h9;
      vtst_pkg::OFF_CTRL4: s = 4'hA;
      vtst_pkg::OFF_SECCFG: s = 4'hB;
      vtst_pkg::OFF_IRQ_STAT: s = 4'hC;
      vtst_pkg::OFF_IRQ_MASK: s = 4'hD;
      vtst_pkg::OFF_LAST_VEC: s = 4'hE;
      vtst_pkg::OFF_ALT_BASE: s = 4'hF;
      default: s = 4'h0;
    endcase
    return s;
  endfunction

  // A function result cannot be bit-selected, so the read select is a net.
  assign rd_sel = reg_sel(s_axi_araddr);

  // The address generator shared by every fetch.
  vtst_vec_calc #(.VEC_W(VEC_W), .BOOT_SEGMENT_LIMIT_W(BOOT_SEGMENT_LIMIT_W)) u_calc (
    .alt_table_select(ctrl2_q[vtst_pkg::B2_ALT_SEL]),
    .alt_table_fuse(alt_table_fuse),
    .boot_seg_defined(boot_seg_defined),
    .boot_segment_limit(boot_segment_limit),
    .vec_num(vec_num),
    .alt_en(alt_en),
    .alt_table_base(alt_base),
    .vec_addr(calc_addr)
  );

  // A write completes once both address and data are held.
  always_comb begin
    do_wr = aw_got_q & w_got_q & ~s_axi_bvalid;
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{wstrb_q[i]}};
    end
    wd = wdata_q & wmask;
    wr1 = do_wr & (reg_sel(awaddr_q) == 4'h8);
    wr2 = do_wr & (reg_sel(awaddr_q) == 4'h9);
    wr4 = do_wr & (reg_sel(awaddr_q) == 4'hA);
    wrst = do_wr & (reg_sel(awaddr_q) == 4'hC);
    wrmk = do_wr & (reg_sel(awaddr_q) == 4'hD);
  end

  // Write address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= vtst_pkg::REG_RST;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= vtst_pkg::RESP_OKAY;
    end else begin
      // Address channel is accepted once per transfer.
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_got_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      // Data channel likewise.
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_got_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      // Response follows both; unmapped or read-only words answer SLVERR.
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr1 | wr2 | wr4 | wrst | wrmk) ?
                       vtst_pkg::RESP_OKAY : vtst_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Generic trap flags: hardware set wins over a write-one clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q <= vtst_pkg::REG_RST[15:0];
    end else begin
      ctrl1_q[vtst_pkg::B1_OSC] <= osc_fail_evt
        | (ctrl1_q[vtst_pkg::B1_OSC] & ~(wr1 & wd[vtst_pkg::B1_OSC]));
      ctrl1_q[vtst_pkg::B1_ADDR] <= addr_err_evt
        | (ctrl1_q[vtst_pkg::B1_ADDR] & ~(wr1 & wd[vtst_pkg::B1_ADDR]));
      ctrl1_q[vtst_pkg::B1_STACK] <= stack_err_evt
        | (ctrl1_q[vtst_pkg::B1_STACK] & ~(wr1 & wd[vtst_pkg::B1_STACK]));
      ctrl1_q[vtst_pkg::B1_MATH] <= divide_by_zero_error
        | (ctrl1_q[vtst_pkg::B1_MATH] & ~(wr1 & wd[vtst_pkg::B1_MATH]));
    end
  end

  // Table select and soft trap enable are plain read/write bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl2_q <= vtst_pkg::REG_RST[15:0];
    end else if (wr2) begin
      ctrl2_q[vtst_pkg::B2_ALT_SEL] <= wd[vtst_pkg::B2_ALT_SEL];
      ctrl2_q[vtst_pkg::B2_SOFT_EN] <= wd[vtst_pkg::B2_SOFT_EN];
    end
  end

  // Hard trap sources: ECC is sticky write-one-clear, soft is read/write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl4_q <= vtst_pkg::REG_RST[15:0];
    end else begin
      ctrl4_q[vtst_pkg::B4_ECC] <= ecc_double_bit_trap
        | (ctrl4_q[vtst_pkg::B4_ECC] & ~(wr4 & wd[vtst_pkg::B4_ECC]));
      if (wr4 && wstrb_q[0]) begin
        ctrl4_q[vtst_pkg::B4_SOFT] <= wd[vtst_pkg::B4_SOFT];
      end
    end
  end

  // Trap events in vector order feed the interrupt status.
  always_comb begin
    hard_pend = ctrl4_q[vtst_pkg::B4_ECC] | (ctrl4_q[vtst_pkg::B4_SOFT]
                & ctrl2_q[vtst_pkg::B2_SOFT_EN]);
    trap_evt = {divide_by_zero_error, stack_err_evt,
                ecc_double_bit_trap | (wr4 & wd[vtst_pkg::B4_SOFT]),
                addr_err_evt, osc_fail_evt};
  end

  // Sticky status, write-one clear, set wins; mask is read/write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= trap_evt
        | (stat_q & ~(wd[vtst_pkg::N_TRAP-1:0] & {vtst_pkg::N_TRAP{wrst}}));
      if (wrmk) begin
        mask_q <= wd[vtst_pkg::N_TRAP-1:0];
      end
      irq_q <= |(stat_q & mask_q);
    end
  end

  // Highest natural priority pending trap is offered to the core.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_req_q <= 1'b0;
      trap_vec_q <= vtst_pkg::V_OSC;
      trap_prio_q <= vtst_pkg::P_NONE;
    end else begin
      trap_req_q <= ctrl1_q[vtst_pkg::B1_OSC] | ctrl1_q[vtst_pkg::B1_ADDR]
        | hard_pend | ctrl1_q[vtst_pkg::B1_STACK] | ctrl1_q[vtst_pkg::B1_MATH];
      if (ctrl1_q[vtst_pkg::B1_OSC]) begin
        trap_vec_q <= vtst_pkg::V_OSC;
        trap_prio_q <= vtst_pkg::P_OSC;
      end else if (ctrl1_q[vtst_pkg::B1_ADDR]) begin
        trap_vec_q <= vtst_pkg::V_ADDR;
        trap_prio_q <= vtst_pkg::P_ADDR;
      end else if (hard_pend) begin
        trap_vec_q <= vtst_pkg::V_HARD;
        trap_prio_q <= vtst_pkg::P_HARD;
      end else if (ctrl1_q[vtst_pkg::B1_STACK]) begin
        trap_vec_q <= vtst_pkg::V_STACK;
        trap_prio_q <= vtst_pkg::P_STACK;
      end else if (ctrl1_q[vtst_pkg::B1_MATH]) begin
        trap_vec_q <= vtst_pkg::V_MATH;
        trap_prio_q <= vtst_pkg::P_MATH;
      end else begin
        trap_vec_q <= vtst_pkg::V_OSC;
        trap_prio_q <= vtst_pkg::P_NONE;
      end
    end
  end

  // Each fetch answers one cycle later with a 24-bit entry address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_ack_q <= 1'b0;
      vec_addr_q <= vtst_pkg::RESET_PC;
      vec_alt_q <= 1'b0;
    end else begin
      vec_ack_q <= vec_req;
      if (vec_req) begin
        vec_addr_q <= calc_addr;
        vec_alt_q <= alt_en;
      end
    end
  end

  // Reset is not vectored: the core restarts at address zero.
  always_ff @(posedge aclk) begin
    start_pc_q <= vtst_pkg::RESET_PC;
  end

  // Read channel returns one word per request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= vtst_pkg::REG_RST;
      s_axi_rresp <= vtst_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rd_sel[3] ?
                     vtst_pkg::RESP_OKAY : vtst_pkg::RESP_SLVERR;
      unique case (rd_sel)
        4'h8: s_axi_rdata <= {16'h0000, ctrl1_q};
        4'h9: s_axi_rdata <= {16'h0000, ctrl2_q};
        4'hA: s_axi_rdata <= {16'h0000, ctrl4_q};
        4'hB: s_axi_rdata <= {16'h0000, alt_table_fuse, 2'h0,
                              boot_segment_limit};
        4'hC: s_axi_rdata <= {27'h000_0000, stat_q};
        4'hD: s_axi_rdata <= {27'h000_0000, mask_q};
        4'hE: s_axi_rdata <= {7'h00, vec_alt_q, vec_addr_q};
        4'hF: s_axi_rdata <= {7'h00, alt_en, alt_base};
        default: s_axi_rdata <= vtst_pkg::REG_RST;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Alternate table is used exactly when fuse, select and segment agree.
  chk_alt_select: assert property (
    vec_req |=> vec_alt_q == $past(alt_table_fuse
      & ctrl2_q[vtst_pkg::B2_ALT_SEL] & boot_seg_defined))
    else $error("alternate table choice wrong");

  // Without the fuse the primary table is kept.
  chk_fuse_gate: assert property (
    vec_req && !alt_table_fuse |=> !vec_alt_q)
    else $error("alternate used without fuse");

  // Without a boot segment fetches stay in the primary table.
  chk_no_boot_seg: assert property (
    vec_req && !boot_seg_defined |=> vec_addr_q ==
      vtst_pkg::VEC0_OFF + {$past(vec_num), 1'b0})
    else $error("primary fetch address wrong");

  // Alternate fetch address equals base plus the primary offset.
  chk_alt_addr: assert property (
    vec_req && alt_en |=> vec_addr_q == {BOOT_SEGMENT_LIMIT_W'(~$past(boot_segment_limit)
      - 1'b1), 11'h000} + vtst_pkg::VEC0_OFF + {$past(vec_num), 1'b0})
    else $error("alternate fetch address wrong");

  // Start address stays at zero.
  chk_start_pc: assert property (
    ##1 start_pc_q == 24'h00_0000)
    else $error("start address not zero");

  // Oscillator trap always wins with priority 15.
  chk_osc_trap: assert property (
    ctrl1_q[vtst_pkg::B1_OSC] |=> trap_req_q && trap_vec_q == 3'h0
      && trap_prio_q == 4'hF)
    else $error("oscillator trap vector wrong");

  // Address error is vector 1 when no oscillator trap pends.
  chk_addr_trap: assert property (
    ctrl1_q[vtst_pkg::B1_ADDR] && !ctrl1_q[vtst_pkg::B1_OSC]
      |=> trap_vec_q == 3'h1 && trap_prio_q == 4'hE)
    else $error("address trap vector wrong");

  // Soft hard-trap source only counts while enabled.
  chk_soft_gate: assert property (
    ctrl1_q[4:1] == 4'h0 && !ctrl4_q[vtst_pkg::B4_ECC]
      && !ctrl2_q[vtst_pkg::B2_SOFT_EN] |=> !trap_req_q)
    else $error("soft hard trap not gated");

  // Stack error beats math error.
  chk_stack_trap: assert property (
    ctrl1_q[4:1] == 4'hA && !hard_pend |=> trap_vec_q == 3'h3
      && trap_prio_q == 4'hC ##1 1'b1)
    else $error("stack trap priority wrong");

  // Interrupt level follows masked status two edges after an event.
  chk_irq_level: assert property (
    osc_fail_evt && mask_q[0] && !wrmk |=> ##1 irq_q)
    else $error("interrupt not raised");

endmodule

// File: verilog/vtst_vec_calc.sv
// Vector fetch address generator for primary and alternate tables.
module vtst_vec_calc #(
  parameter int VEC_W = 7,
  parameter int BOOT_SEGMENT_LIMIT_W = 13
) (
  // Table selection controls.
  input wire logic alt_table_select,
  input wire logic alt_table_fuse,
  input wire logic boot_seg_defined,
  input wire logic [BOOT_SEGMENT_LIMIT_W-1:0] boot_segment_limit,
  // Requested vector number.
  input wire logic [VEC_W-1:0] vec_num,
  // Results.
  output logic alt_en,
  output logic [23:0] alt_table_base,
  output logic [23:0] vec_addr
);

  // Base plus page shift must fill the 24-bit address exactly.
  if (BOOT_SEGMENT_LIMIT_W + vtst_pkg::PAGE_SHIFT != vtst_pkg::ADDR_W) begin : g_chk_bs
    $error("vtst_vec_calc: boot segment limit width does not fit");
  end
  if (VEC_W < 3 || VEC_W > 12) begin : g_chk_vw
    $error("vtst_vec_calc: vector number width out of range");
  end

  // Complemented limit minus one, taken at the field width.
  logic [BOOT_SEGMENT_LIMIT_W-1:0] page_idx;
  // Twice the vector number, widened to an address.
  logic [23:0] vec_off;

  // The alternate table needs the fuse, the select bit and a boot segment.
  always_comb begin
    alt_en = alt_table_fuse & alt_table_select & boot_seg_defined;
  end

  // Alternate base sits at the start of the last boot segment page.
  always_comb begin
    page_idx = BOOT_SEGMENT_LIMIT_W'(~boot_segment_limit - 1'b1);
    alt_table_base = {page_idx, {vtst_pkg::PAGE_SHIFT{1'b0}}};
  end

  // Both tables share one layout, so only the base differs.
  always_comb begin
    vec_off = {{(24 - VEC_W - 1){1'b0}}, vec_num, 1'b0};
    vec_addr = (alt_en ? alt_table_base : 24'h00_0000)
               + vtst_pkg::VEC0_OFF + vec_off;
  end

endmodule
